//--- core/afc_ctrl.sv
`timescale 1ns/1ps
// How it works
// [R1] device clears both pointers while reset_n_input is low
// [R2] no write command is issued before a reset pulse has been sent
// [R3] both strobes held high over reset setup and recovery intervals
// [R4] device releases half_full_flag_n after reset
// [R5] a write strobe starts only while full_flag_n is high
// [R6] write data stands before and across the write strobe rising edge
// [R7] device stores words in consecutive locations by its own pointer
// [R8] half_full_flag_n low past half depth, clears on read rising edge
// [R9] full_flag_n low blocks writes; high again after a read
// [R10] device ignores write strobe while full
// [R11] a read strobe starts only while empty_flag_n is high
// [R12] read data bus is taken before the read strobe rises
// [R13] empty_flag_n low after last read; further reads refused
// [R14] empty_flag_n high again after a write into an empty device
// [R15] device ignores read strobe while empty
// [R16] first_device_select_n doubles as replay request in single mode
// [R17] replay pulse moves the read pointer home, write pointer stays
// [R18] both strobes held high during the whole replay pulse
// [R19] replay only offered while fewer than depth words written
// [R20] replay refused in chain mode; half flag re-read after it
// [R21] chain_token_in_n grounded selects single device mode
// [R22] words are 9 bits wide in both directions
// [R23] full_flag_n asserts after depth writes with no reads
// [R24] empty_flag_n asserts when pointers meet
// [R25] chain_token_out_n pulses at the device's last location
// [R26] depth is a package constant, count width follows it; CNT_W is a fixed 16 here
module afc_ctrl
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic reset_n_input_out,
    output logic write_n_out,
    output logic read_n_out,
    output logic replay_request_n_out,
    output logic chain_token_in_n_out,
    output logic [8:0] write_data_bus_out,
    input wire logic [8:0] read_data_bus_in,
    input wire logic full_flag_n_in,
    input wire logic empty_flag_n_in,
    input wire logic half_full_flag_n_in
);
    afc_pkg::afc_state_t state;
    afc_pkg::afc_op_t op;
    logic [8:0] wdata_hold;
    logic [8:0] rdata_hold;
    logic [1:0] ctrl;
    logic init_done;
    logic refused;
    logic rvalid;
    logic [afc_pkg::CNT_W-1:0] since_reset;
    logic timer_load;
    logic [3:0] timer_count;
    logic timer_done;
    logic cmd_wr;
    logic accept_reset;
    logic accept_write;
    logic accept_read;
    logic accept_replay;
    logic any_cmd;
    logic replay_ok;
    logic [3:0] pulse_len;

    function automatic logic [3:0] afc_phase_len(input afc_pkg::afc_op_t o,
                                                  input logic pulse);
        if (o == afc_pkg::AFC_OP_RESET)
            afc_phase_len = pulse ? afc_pkg::RESET_PULSE_CYC
                                  : afc_pkg::RESET_RECOVERY_CYC;
        else
            afc_phase_len = pulse ? afc_pkg::PULSE_CYC
                                  : afc_pkg::RECOVERY_CYC;
    endfunction : afc_phase_len

    assign cmd_wr = wr_in && (addr_in == afc_pkg::ADDR_CMD);
    assign any_cmd = cmd_wr && (state == afc_pkg::AFC_IDLE);
    assign replay_ok = !ctrl[afc_pkg::CTRL_CHAIN_BIT] &&
        (since_reset < afc_pkg::CNT_W'(afc_pkg::DEPTH)); // see [R19] see [R20]
    assign accept_reset = any_cmd && wdata_in[afc_pkg::CMD_RESET_BIT];
    assign accept_write = any_cmd && !accept_reset &&
        wdata_in[afc_pkg::CMD_WRITE_BIT] && init_done &&
        full_flag_n_in; // see [R2] see [R5] see [R9] see [R10]
    assign accept_read = any_cmd && !accept_reset &&
        !wdata_in[afc_pkg::CMD_WRITE_BIT] &&
        wdata_in[afc_pkg::CMD_READ_BIT] && init_done &&
        empty_flag_n_in; // see [R11] see [R13] see [R15]
    assign accept_replay = any_cmd && !accept_reset &&
        !wdata_in[afc_pkg::CMD_WRITE_BIT] &&
        !wdata_in[afc_pkg::CMD_READ_BIT] &&
        wdata_in[afc_pkg::CMD_REPLAY_BIT] && init_done && replay_ok;
    assign pulse_len = afc_phase_len(op, 1'b1);

    always_comb
    begin
        timer_load = 1'b0;
        timer_count = 4'h0;
        if (accept_reset)
        begin
            timer_load = 1'b1;
            timer_count = afc_pkg::RESET_SETUP_CYC; // see [R3]
        end
        else if (accept_write)
        begin
            timer_load = 1'b1;
            timer_count = afc_pkg::DATA_SETUP_CYC; // see [R6]
        end
        else if (accept_read || accept_replay)
        begin
            timer_load = 1'b1;
            timer_count = 4'h1;
        end
        else if (timer_done)
        begin
            unique case (state)
                afc_pkg::AFC_SETUP:
                begin
                    timer_load = 1'b1;
                    timer_count = pulse_len;
                end
                afc_pkg::AFC_PULSE:
                begin
                    timer_load = 1'b1;
                    timer_count = afc_phase_len(op, 1'b0);
                end
                afc_pkg::AFC_HOLD:
                begin
                    timer_load = 1'b1;
                    timer_count = afc_pkg::FLAG_CYC;
                end
                afc_pkg::AFC_IDLE, afc_pkg::AFC_RECOVER:
                begin
                    timer_load = 1'b0;
                end
            endcase
        end
    end

    afc_timer u_timer
    (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    // sequence: setup, strobe pulse, recovery, flag settle
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            state <= afc_pkg::AFC_IDLE;
        else if (accept_reset || accept_write || accept_read ||
                 accept_replay)
            state <= afc_pkg::AFC_SETUP;
        else if (timer_done)
        begin
            unique case (state)
                afc_pkg::AFC_IDLE: state <= afc_pkg::AFC_IDLE;
                afc_pkg::AFC_SETUP: state <= afc_pkg::AFC_PULSE;
                afc_pkg::AFC_PULSE: state <= afc_pkg::AFC_HOLD;
                afc_pkg::AFC_HOLD: state <= afc_pkg::AFC_RECOVER;
                afc_pkg::AFC_RECOVER: state <= afc_pkg::AFC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            op <= afc_pkg::AFC_OP_RESET;
        else if (accept_reset)
            op <= afc_pkg::AFC_OP_RESET;
        else if (accept_write)
            op <= afc_pkg::AFC_OP_WRITE;
        else if (accept_read)
            op <= afc_pkg::AFC_OP_READ;
        else if (accept_replay)
            op <= afc_pkg::AFC_OP_REPLAY;
    end

    // strobes stay high outside their own pulse phase, so reset and
    // replay always see both strobes idle
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            reset_n_input_out <= 1'b1;
            write_n_out <= 1'b1;
            read_n_out <= 1'b1;
            replay_request_n_out <= 1'b1;
        end
        else
        begin
            reset_n_input_out <= !(state == afc_pkg::AFC_SETUP &&
                timer_done && op == afc_pkg::AFC_OP_RESET) &&
                !(state == afc_pkg::AFC_PULSE && !timer_done &&
                op == afc_pkg::AFC_OP_RESET); // see [R1] see [R3]
            write_n_out <= !(state == afc_pkg::AFC_SETUP &&
                timer_done && op == afc_pkg::AFC_OP_WRITE) &&
                !(state == afc_pkg::AFC_PULSE && !timer_done &&
                op == afc_pkg::AFC_OP_WRITE); // see [R5] see [R6]
            read_n_out <= !(state == afc_pkg::AFC_SETUP &&
                timer_done && op == afc_pkg::AFC_OP_READ) &&
                !(state == afc_pkg::AFC_PULSE && !timer_done &&
                op == afc_pkg::AFC_OP_READ); // see [R11]
            // chain mode: a level that copies CTRL_FIRST_BIT, grounded while that bit is clear and high while it is set
            replay_request_n_out <= ctrl[afc_pkg::CTRL_CHAIN_BIT] ?
                ctrl[afc_pkg::CTRL_FIRST_BIT] :
                !(state == afc_pkg::AFC_SETUP && timer_done &&
                op == afc_pkg::AFC_OP_REPLAY) &&
                !(state == afc_pkg::AFC_PULSE && !timer_done &&
                op == afc_pkg::AFC_OP_REPLAY); // see [R16] see [R17] see [R18]
        end
    end

    // chain_token_in_n carries the chain bit: high in chain mode, grounded in single mode
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            chain_token_in_n_out <= 1'b0;
        else
            chain_token_in_n_out <= ctrl[afc_pkg::CTRL_CHAIN_BIT]; // see [R21]
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            wdata_hold <= 9'h000;
        else if (wr_in && addr_in == afc_pkg::ADDR_WDATA &&
                 state == afc_pkg::AFC_IDLE)
            wdata_hold <= wdata_in[8:0]; // see [R22]
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            write_data_bus_out <= 9'h000;
        else
            write_data_bus_out <= wdata_hold; // see [R6]
    end

    // sample late in the pulse, after access time and before the rise
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            rdata_hold <= 9'h000;
        else if (state == afc_pkg::AFC_PULSE && timer_done &&
                 op == afc_pkg::AFC_OP_READ)
            rdata_hold <= read_data_bus_in; // see [R12] see [R22]
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            rvalid <= 1'b0;
        else if (state == afc_pkg::AFC_PULSE && timer_done &&
                 op == afc_pkg::AFC_OP_READ)
            rvalid <= 1'b1;
        else if (rd_in && addr_in == afc_pkg::ADDR_RDATA)
            rvalid <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            init_done <= 1'b0;
        else if (state == afc_pkg::AFC_RECOVER && timer_done &&
                 op == afc_pkg::AFC_OP_RESET)
            init_done <= 1'b1; // see [R2]
    end

    // writes since reset; saturates so replay stays refused once wrapped
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            since_reset <= '0;
        else if (accept_reset)
            since_reset <= '0;
        else if (accept_write && since_reset != '1)
            since_reset <= since_reset + 1'b1; // see [R19] see [R26]
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            refused <= 1'b0;
        else if (cmd_wr && !(accept_reset || accept_write ||
                 accept_read || accept_replay) &&
                 wdata_in[3:0] != 4'h0)
            refused <= 1'b1;
        else if (accept_reset || accept_write || accept_read ||
                 accept_replay)
            refused <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            ctrl <= afc_pkg::CTRL_RESET;
        else if (wr_in && addr_in == afc_pkg::ADDR_CTRL &&
                 state == afc_pkg::AFC_IDLE)
            ctrl <= wdata_in[1:0];
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            unique case (addr_in)
                afc_pkg::ADDR_WDATA: rdata_out <= {7'h00, wdata_hold};
                afc_pkg::ADDR_RDATA: rdata_out <= {7'h00, rdata_hold};
                afc_pkg::ADDR_STATUS:
                    rdata_out <= {8'h00, replay_ok, rvalid, refused,
                        init_done, !half_full_flag_n_in, !full_flag_n_in,
                        !empty_flag_n_in,
                        state != afc_pkg::AFC_IDLE}; // see [R8] see [R24]
                afc_pkg::ADDR_CTRL: rdata_out <= {14'h0000, ctrl};
                afc_pkg::ADDR_COUNT: rdata_out <= since_reset;
                default: rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end
endmodule : afc_ctrl

//--- core/afc_pkg.sv
package afc_pkg;
    localparam int DATA_W = 9;
    localparam int DEPTH = 512;
    localparam int CLK_PERIOD_NS = 10;
    // strobe/reset timing in ns; longest of the speed grades
    localparam int RESET_PULSE_NS = 35;
    localparam int RESET_SETUP_NS = 35;
    localparam int RESET_RECOVERY_NS = 10;
    localparam int PULSE_NS = 35;
    localparam int RECOVERY_NS = 10;
    localparam int DATA_SETUP_NS = 18;
    localparam int ACCESS_NS = 35;
    localparam int FLAG_NS = 45;
    localparam logic [3:0] RESET_PULSE_CYC =
        4'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RESET_SETUP_CYC =
        4'((RESET_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RESET_RECOVERY_CYC =
        4'((RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] PULSE_CYC =
        4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RECOVERY_CYC =
        4'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] DATA_SETUP_CYC =
        4'((DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ACCESS_CYC =
        4'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] FLAG_CYC =
        4'((FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // register map of the controller, word offsets
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_WDATA = 4'h1;
    localparam logic [3:0] ADDR_RDATA = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_COUNT = 4'h5;
    // command bits
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_READ_BIT = 2;
    localparam int CMD_REPLAY_BIT = 3;
    // status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_HALF_BIT = 3;
    localparam int ST_INIT_BIT = 4;
    localparam int ST_REFUSED_BIT = 5;
    localparam int ST_RVALID_BIT = 6;
    localparam int ST_REPLAY_OK_BIT = 7;
    // control bits
    localparam int CTRL_CHAIN_BIT = 0;
    localparam int CTRL_FIRST_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int CNT_W = 16;
    typedef enum logic [2:0] {
        AFC_IDLE,
        AFC_SETUP,
        AFC_PULSE,
        AFC_HOLD,
        AFC_RECOVER
    } afc_state_t;
    typedef enum logic [1:0] {
        AFC_OP_RESET,
        AFC_OP_WRITE,
        AFC_OP_READ,
        AFC_OP_REPLAY
    } afc_op_t;
endpackage : afc_pkg

//--- core/afc_timer.sv
`timescale 1ns/1ps
// down counter that paces each phase of a strobe sequence
module afc_timer
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic load_in,
    input wire logic [3:0] count_in,
    output logic done_out
);
    logic [3:0] remain;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            remain <= 4'h0;
        else if (load_in)
            remain <= count_in;
        else if (remain != 4'h0)
            remain <= remain - 4'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            done_out <= 1'b1;
        else if (load_in)
            done_out <= (count_in <= 4'h1);
        else
            done_out <= (remain <= 4'h2);
    end
endmodule : afc_timer

//--- verification/afc_ctrl_properties.sv
`timescale 1ns/1ps
module afc_ctrl_properties
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reset_n_input_out,
    input wire logic write_n_out,
    input wire logic read_n_out,
    input wire logic replay_request_n_out,
    input wire logic chain_token_in_n_out,
    input wire logic [8:0] write_data_bus_out,
    input wire logic full_flag_n_in,
    input wire logic empty_flag_n_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic init_seen;
    logic prev_write_n;
    logic [9:0] wr_cnt;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            init_seen <= 1'b0;
        else if (!reset_n_input_out)
            init_seen <= 1'b1;
    end
    // saturating count of write pulses since the last device reset
    always_ff @(posedge clk_in)
    begin
        prev_write_n <= write_n_out;
        if (srst_in || !reset_n_input_out)
            wr_cnt <= 10'h000;
        else if (prev_write_n && !write_n_out && wr_cnt != 10'h3ff)
            wr_cnt <= wr_cnt + 10'h001;
    end
    a_reset_strobes_idle: assert property (
        !reset_n_input_out |-> write_n_out && read_n_out)
        else $error("strobe low while device reset is low");
    a_reset_recovery_hold: assert property (
        $rose(reset_n_input_out) |-> (write_n_out && read_n_out) [*2])
        else $error("strobe low inside reset recovery");
    a_write_needs_room: assert property (
        $fell(write_n_out) |-> $past(full_flag_n_in))
        else $error("write pulse started while device full");
    a_read_needs_data: assert property (
        $fell(read_n_out) |-> $past(empty_flag_n_in))
        else $error("read pulse started while device empty");
    a_wdata_held: assert property (
        !write_n_out |-> $stable(write_data_bus_out) ##1
        $stable(write_data_bus_out))
        else $error("write data moved around write pulse");
    a_write_after_init: assert property (
        $fell(write_n_out) |-> init_seen)
        else $error("write pulse before any device reset");
    a_replay_strobes_idle: assert property (
        !chain_token_in_n_out && !$past(chain_token_in_n_out) &&
        !replay_request_n_out |-> write_n_out && read_n_out)
        else $error("strobe low during replay pulse");
    a_replay_below_depth: assert property (
        $fell(replay_request_n_out) && !chain_token_in_n_out |->
        wr_cnt < 10'(afc_pkg::DEPTH))
        else $error("replay after a full depth of writes");
    a_replay_no_chain: assert property (
        chain_token_in_n_out && $past(chain_token_in_n_out) |->
        !$fell(replay_request_n_out))
        else $error("replay pulse in chain mode");
endmodule : afc_ctrl_properties

//--- verification/afc_fifo_model.sv
`timescale 1ns/1ps
// behavioural device; pointers are unbounded ints, wrapped at memory access
module afc_fifo_model
(
    input wire logic reset_n_in,
    input wire logic write_n_in,
    input wire logic read_n_in,
    input wire logic replay_n_in,
    input wire logic chain_n_in,
    input wire logic [8:0] wdata_in,
    output logic [8:0] rdata_out,
    output logic full_n_out,
    output logic empty_n_out,
    output logic half_n_out
);
    logic [8:0] mem [0:afc_pkg::DEPTH-1];
    int wp = 0;
    int rp = 0;
    bit w_ok;
    bit r_ok;
    initial rdata_out = 9'h0a5;
    initial half_n_out = 1'b1;
    assign full_n_out = (wp - rp) != afc_pkg::DEPTH;
    assign empty_n_out = wp != rp;
    always @(negedge reset_n_in)
    begin
        wp = 0;
        rp = 0;
        half_n_out = 1'b1;
    end
    // in chain mode the shared flag pin pulses at the last location
    always @(negedge write_n_in)
    begin
        w_ok = full_n_out && reset_n_in;
        if (chain_n_in)
            half_n_out = !(w_ok &&
                wp % afc_pkg::DEPTH == afc_pkg::DEPTH - 1);
        else if (w_ok && wp - rp >= afc_pkg::DEPTH / 2)
            half_n_out = 1'b0;
    end
    always @(posedge write_n_in)
    begin
        if (w_ok)
        begin
            mem[wp % afc_pkg::DEPTH] = wdata_in;
            wp++;
        end
        w_ok = 1'b0;
        if (chain_n_in)
            half_n_out = 1'b1;
    end
    always @(negedge read_n_in)
    begin
        r_ok = empty_n_out && reset_n_in;
        if (r_ok)
            rdata_out = mem[rp % afc_pkg::DEPTH];
    end
    // released bus shows the inverse of its last value, never a hold
    always @(posedge read_n_in)
    begin
        if (r_ok)
        begin
            rp++;
            if (wp - rp <= afc_pkg::DEPTH / 2)
                half_n_out = 1'b1;
        end
        r_ok = 1'b0;
        rdata_out = ~rdata_out;
    end
    always @(negedge replay_n_in)
    begin
        if (!chain_n_in)
        begin
            rp = 0;
            half_n_out = 1'(wp <= afc_pkg::DEPTH / 2);
        end
    end
endmodule : afc_fifo_model

//--- verification/test_async_fifo_flags_retransmit.sv
`timescale 1ns/1ps
module test_async_fifo_flags_retransmit;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] rdata_out;
    logic rst_n, wr_n, rd_n, replay_n, chain_n, full_n, empty_n, half_n;
    logic [8:0] wbus, rbus;
    logic [8:0] exp_q[$];
    logic [8:0] hist_q[$];
    logic [15:0] st;
    int err_count = 0;
    int n_tests = 0;
    integer seed = 32'h82add539;
    always #5 clk_in = ~clk_in;
    afc_ctrl dut_u (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .reset_n_input_out(rst_n),
        .write_n_out(wr_n), .read_n_out(rd_n),
        .replay_request_n_out(replay_n), .chain_token_in_n_out(chain_n),
        .write_data_bus_out(wbus), .read_data_bus_in(rbus),
        .full_flag_n_in(full_n), .empty_flag_n_in(empty_n),
        .half_full_flag_n_in(half_n));
    afc_fifo_model dev_u (.reset_n_in(rst_n), .write_n_in(wr_n),
        .read_n_in(rd_n), .replay_n_in(replay_n), .chain_n_in(chain_n),
        .wdata_in(wbus), .rdata_out(rbus), .full_n_out(full_n),
        .empty_n_out(empty_n), .half_n_out(half_n));
    task check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : check
    task bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : bus_wr
    task bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        d = rdata_out;
    endtask : bus_rd
    // at least two polls so a refusal has landed in the status word
    task do_cmd(input int b, input bit acc);
        int i;
        bus_wr(afc_pkg::ADDR_CMD, 16'(1 << b));
        for (i = 0; i < 200; i++)
        begin
            bus_rd(afc_pkg::ADDR_STATUS, st);
            if (i > 0 && st[afc_pkg::ST_BUSY_BIT] === 1'b0)
                break;
        end
        check("busy", 16'h0000, 16'(st[afc_pkg::ST_BUSY_BIT]));
        check("refused", 16'(!acc), 16'(st[afc_pkg::ST_REFUSED_BIT]));
    endtask : do_cmd
    task push(input bit acc);
        logic [8:0] d;
        d = 9'($random(seed));
        bus_wr(afc_pkg::ADDR_WDATA, {7'h00, d});
        do_cmd(afc_pkg::CMD_WRITE_BIT, acc);
        if (acc)
        begin
            exp_q.push_back(d);
            hist_q.push_back(d);
        end
    endtask : push
    task pop(input bit acc);
        logic [15:0] v;
        do_cmd(afc_pkg::CMD_READ_BIT, acc);
        if (acc)
        begin
            bus_rd(afc_pkg::ADDR_RDATA, v);
            check("read word", {7'h00, exp_q.pop_front()}, {7'h00, v[8:0]});
        end
    endtask : pop
    task flags(input bit h);
        bus_rd(afc_pkg::ADDR_STATUS, st);
        check("flags", 16'({h, exp_q.size() == afc_pkg::DEPTH,
            exp_q.size() == 0}), 16'(st[3:1]));
    endtask : flags
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #600_000;
        err_count++;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        push(1'b0);
        do_cmd(afc_pkg::CMD_RESET_BIT, 1'b1);
        flags(1'b0);
        pop(1'b0);
        bus_wr(afc_pkg::ADDR_CTRL, 16'h0001);
        do_cmd(afc_pkg::CMD_REPLAY_BIT, 1'b0);
        check("chain pin", 16'h0001, 16'(chain_n));
        check("first pin", 16'h0000, 16'(replay_n));
        bus_wr(afc_pkg::ADDR_CTRL, 16'h0003);
        bus_rd(afc_pkg::ADDR_CTRL, st);
        check("ctrl", 16'h0003, st);
        check("first pin", 16'h0001, 16'(replay_n));
        bus_wr(afc_pkg::ADDR_CTRL, 16'h0000);
        bus_rd(afc_pkg::ADDR_CTRL, st);
        check("chain pin", 16'h0000, 16'(chain_n));
        repeat (256) push(1'b1);
        flags(1'b0);
        push(1'b1);
        flags(1'b1);
        pop(1'b1);
        flags(1'b0);
        repeat (2) pop(1'b1);
        do_cmd(afc_pkg::CMD_REPLAY_BIT, 1'b1);
        exp_q = hist_q;
        flags(1'b1);
        pop(1'b1);
        while (exp_q.size() < afc_pkg::DEPTH) push(1'b1);
        flags(1'b1);
        push(1'b0);
        bus_rd(afc_pkg::ADDR_COUNT, st);
        check("write count", 16'(hist_q.size()), st);
        do_cmd(afc_pkg::CMD_REPLAY_BIT, 1'b0);
        pop(1'b1);
        flags(1'b1);
        while (exp_q.size() > 0) pop(1'b1);
        flags(1'b0);
        pop(1'b0);
        push(1'b1);
        flags(1'b0);
        bus_rd(4'hf, st);
        check("unmapped", 16'h0000, st);
        bus_wr(afc_pkg::ADDR_WDATA, 16'h01a5);
        bus_rd(afc_pkg::ADDR_WDATA, st);
        check("wdata", 16'h01a5, st);
        print_verdict;
    end
endmodule : test_async_fifo_flags_retransmit
bind afc_ctrl afc_ctrl_properties chk_u (.clk_in(clk_in), .srst_in(srst_in),
    .reset_n_input_out(reset_n_input_out), .write_n_out(write_n_out),
    .read_n_out(read_n_out), .replay_request_n_out(replay_request_n_out),
    .chain_token_in_n_out(chain_token_in_n_out),
    .write_data_bus_out(write_data_bus_out),
    .full_flag_n_in(full_flag_n_in), .empty_flag_n_in(empty_flag_n_in));
